// >>> hw/asrr_pkg.sv
package asrr_pkg;

	// Register byte offsets, decoded on haddr[7:0]
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_DIV    = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_DATA   = 8'h0c;

	localparam int unsigned CTRL_W = 4;
	localparam int unsigned DIV_W  = 16;
	localparam int unsigned DATA_W = 8;

	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
	localparam logic [DIV_W-1:0]  DIV_RESET  = 16'h0000;

	// Status word bit positions
	localparam int unsigned ST_RXC_BIT  = 0;
	localparam int unsigned ST_FE_BIT   = 1;
	localparam int unsigned ST_DOR_BIT  = 2;
	localparam int unsigned ST_PE_BIT   = 3;
	localparam int unsigned ST_BUSY_BIT = 4;
	localparam int unsigned ST_PIN_BIT  = 5;

	// Samples per bit and centre vote window
	localparam logic [4:0] SPB_NORMAL        = 5'h10;
	localparam logic [4:0] SPB_DOUBLE        = 5'h08;
	localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
	localparam logic [4:0] VOTE_LAST_NORMAL  = 5'h0a;
	localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
	localparam logic [4:0] VOTE_LAST_DOUBLE  = 5'h06;

	localparam logic       HTRANS_ACTIVE_BIT = 1'b1;
	localparam logic       HRESP_OKAY        = 1'b0;

	typedef struct packed {
		logic podd;
		logic pen;
		logic dbl;
		logic en;
	} asrr_ctrl_t;

	typedef struct packed {
		logic              pe;
		logic              dor;
		logic              fe;
		logic [DATA_W-1:0] data;
	} asrr_entry_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_START  = 3'b001,
		ST_DATA   = 3'b011,
		ST_PARITY = 3'b010,
		ST_STOP   = 3'b110
	} asrr_state_t;

endpackage

// >>> hw/asrr_bit_timer.sv
`timescale 1ns/1ps
`default_nettype none
module asrr_bit_timer (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       sample_tick,
	input  wire logic       restart,
	input  wire logic       run,
	input  wire logic       double_speed,
	input  wire logic       rx_sample,
	output logic            vote_done,
	output logic            vote_bit,
	output logic [4:0]      sample_num
);
	import asrr_pkg::*;

	logic [4:0] cnt;
	logic [4:0] next_cnt;
	logic [1:0] votes;
	logic [4:0] last;
	logic [4:0] vfirst;
	logic [4:0] vlast;

	assign last   = double_speed ? SPB_DOUBLE : SPB_NORMAL;
	assign vfirst = double_speed ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
	assign vlast  = double_speed ? VOTE_LAST_DOUBLE : VOTE_LAST_NORMAL;
	assign next_cnt = (cnt == last) ? 5'h01 : cnt + 5'h01;
	assign sample_num = cnt;

	// Falling-edge sample is sample one of the start bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 5'h00;
		end else if (restart) begin
			cnt <= 5'h01;
		end else if (!run) begin
			cnt <= 5'h00;
		end else if (sample_tick) begin
			cnt <= next_cnt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			votes <= 2'h0;
		end else if (run && sample_tick && next_cnt >= vfirst && next_cnt < vlast) begin
			votes <= {votes[0], rx_sample};
		end
	end

	// Last centre sample is voted in the same cycle it arrives
	assign vote_done = run && sample_tick && !restart && (next_cnt == vlast);
	assign vote_bit  = (votes[1] & votes[0]) | (votes[1] & rx_sample) | (votes[0] & rx_sample);

	cnt_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
		run |-> cnt <= last)
		else $error("sample counter beyond bit length");

	vote_position_a: assert property (@(posedge hclk) disable iff (!hresetn)
		vote_done && !restart && $stable(double_speed) |=> cnt == vlast)
		else $error("vote taken off the centre sample");

endmodule // asrr_bit_timer
`default_nettype wire

// >>> hw/asrr_rx.sv
`timescale 1ns/1ps
`default_nettype none
module asrr_rx #(
	parameter int unsigned DEPTH = 2
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        serial_input_pin,
	output logic             serial_pin_override
);
	import asrr_pkg::*;

	localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(DEPTH - 1);
	localparam logic [3:0]       LAST_BIT   = 4'(DATA_W - 1);

	asrr_ctrl_t             ctrl;
	logic [DIV_W-1:0]       divisor;
	logic [DIV_W-1:0]       div_cnt;
	logic                   sample_tick;

	asrr_state_t            state;
	logic                   rx_prev;
	logic                   start_edge;
	logic                   frame_dbl;
	logic                   frame_pen;
	logic                   frame_podd;
	logic [3:0]             bit_idx;
	logic [DATA_W-1:0]      shift;
	logic                   frame_pe;
	logic                   vote_done;
	logic                   vote_bit;
	logic                   frame_done;
	asrr_entry_t            frame_entry;

	asrr_entry_t            mem [DEPTH];
	logic [PTR_W-1:0]       rd_ptr;
	logic [PTR_W-1:0]       wr_ptr;
	logic [CNT_W-1:0]       count;
	logic [CNT_W-1:0]       next_count;
	logic                   room;
	asrr_entry_t            held;
	logic                   held_valid;
	logic                   push_held;
	logic                   push_direct;
	logic                   push;
	logic                   pop;
	logic                   held_load;
	logic                   overrun_evt;
	asrr_entry_t            push_entry;
	asrr_entry_t            head;

	logic                   addr_valid;
	logic                   wr_pend;
	logic [7:0]             wr_addr;
	logic                   data_read;
	logic [31:0]            status_word;

	// Bus: zero wait states, always OKAY
	assign hreadyout  = 1'b1;
	assign hresp      = HRESP_OKAY;
	assign addr_valid = hsel && hready && (htrans[1] == HTRANS_ACTIVE_BIT);
	assign data_read  = addr_valid && !hwrite && (haddr[7:0] == ADDR_DATA);

	assign serial_pin_override = ctrl.en;

	// Sample clock divider; held in reset while disabled so timing restarts cleanly
	assign sample_tick = ctrl.en && (div_cnt == '0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= '0;
		end else if (!ctrl.en) begin
			div_cnt <= '0;
		end else if (div_cnt == '0) begin
			div_cnt <= divisor;
		end else begin
			div_cnt <= div_cnt - 1'b1;
		end
	end

	// Edge watch compares consecutive samples; after the stop vote the next low
	// sample already counts, so a sender in either speed may start right after the vote
	assign start_edge = (state == ST_IDLE) && sample_tick && rx_prev && !serial_input_pin;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_prev <= 1'b1;
		end else if (!ctrl.en) begin
			rx_prev <= 1'b1;
		end else if (sample_tick) begin
			rx_prev <= serial_input_pin;
		end
	end

	asrr_bit_timer asrr_bit_timer_inst (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.sample_tick  (sample_tick),
		.restart      (start_edge),
		.run          (state != ST_IDLE),
		.double_speed (frame_dbl),
		.rx_sample    (serial_input_pin),
		.vote_done    (vote_done),
		.vote_bit     (vote_bit),
		.sample_num   ()
	);

	// Mode bits are latched per frame so a mid-frame write cannot skew timing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_dbl  <= 1'b0;
			frame_pen  <= 1'b0;
			frame_podd <= 1'b0;
		end else if (start_edge) begin
			frame_dbl  <= ctrl.dbl;
			frame_pen  <= ctrl.pen;
			frame_podd <= ctrl.podd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_IDLE;
		end else if (!ctrl.en) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start_edge) begin
						state <= ST_START;
					end
				end
				ST_START: begin
					if (vote_done) begin
						state <= vote_bit ? ST_IDLE : ST_DATA;
					end
				end
				ST_DATA: begin
					if (vote_done && bit_idx == LAST_BIT) begin
						state <= frame_pen ? ST_PARITY : ST_STOP;
					end
				end
				ST_PARITY: begin
					if (vote_done) begin
						state <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (vote_done) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_idx <= 4'h0;
			shift   <= '0;
		end else if (start_edge) begin
			bit_idx <= 4'h0;
		end else if (state == ST_DATA && vote_done) begin
			bit_idx <= bit_idx + 4'h1;
			shift   <= {vote_bit, shift[DATA_W-1:1]};
		end
	end

	// Even parity: data plus parity xor to zero; odd: to one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_pe <= 1'b0;
		end else if (start_edge) begin
			frame_pe <= 1'b0;
		end else if (state == ST_PARITY && vote_done) begin
			frame_pe <= (^shift) ^ vote_bit ^ frame_podd;
		end
	end

	assign frame_done  = (state == ST_STOP) && vote_done && ctrl.en;
	assign frame_entry = '{pe: frame_pe, dor: 1'b0, fe: !vote_bit, data: shift};

	// Buffer of DEPTH entries plus the separate held register as holding slot
	assign room        = (count != FULL_COUNT);
	assign push_held   = held_valid && room;
	assign push_direct = frame_done && !held_valid && room;
	assign push        = push_held || push_direct;
	assign push_entry  = push_held ? held : frame_entry;
	assign held_load   = frame_done && (held_valid ? push_held : !room);
	assign overrun_evt = start_edge && held_valid && !room;
	assign pop         = data_read && (count != '0);
	assign head        = mem[rd_ptr];

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count  <= '0;
			rd_ptr <= '0;
			wr_ptr <= '0;
		end else if (!ctrl.en) begin
			count  <= '0;
			rd_ptr <= '0;
			wr_ptr <= '0;
		end else begin
			count <= next_count;
			if (pop) begin
				rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
			end
			if (push) begin
				wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge hclk) begin
		if (push && ctrl.en) begin
			mem[wr_ptr] <= push_entry;
		end
	end

	// A frame that finishes while a character is held and the buffer is full is lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			held       <= '0;
			held_valid <= 1'b0;
		end else if (!ctrl.en) begin
			held_valid <= 1'b0;
		end else if (held_load) begin
			held       <= frame_entry;
			held_valid <= 1'b1;
		end else if (push_held) begin
			held_valid <= 1'b0;
		end else if (overrun_evt) begin
			held.dor   <= 1'b1;
		end
	end

	always_comb begin
		status_word = 32'h0;
		status_word[ST_RXC_BIT]  = (count != '0);
		status_word[ST_FE_BIT]   = (count != '0) && head.fe;
		status_word[ST_DOR_BIT]  = (count != '0) && head.dor;
		status_word[ST_PE_BIT]   = (count != '0) && head.pe;
		status_word[ST_BUSY_BIT] = (state != ST_IDLE);
		status_word[ST_PIN_BIT]  = ctrl.en;
	end

	// Read data is captured in the address phase, so a data read pops at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (addr_valid && !hwrite) begin
			unique case (haddr[7:0])
				ADDR_CTRL:   hrdata <= {{(32-CTRL_W){1'b0}}, ctrl};
				ADDR_DIV:    hrdata <= {{(32-DIV_W){1'b0}}, divisor};
				ADDR_STATUS: hrdata <= status_word;
				ADDR_DATA:   hrdata <= (count != '0) ? {{(32-DATA_W){1'b0}}, head.data} : 32'h0;
				default:     hrdata <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= addr_valid && hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl    <= asrr_ctrl_t'(CTRL_RESET);
			divisor <= DIV_RESET;
		end else if (wr_pend) begin
			if (wr_addr == ADDR_CTRL) begin
				ctrl <= asrr_ctrl_t'(hwdata[CTRL_W-1:0]);
			end
			if (wr_addr == ADDR_DIV) begin
				divisor <= hwdata[DIV_W-1:0];
			end
		end
	end

	disable_abort_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!ctrl.en |=> state == ST_IDLE && !held_valid)
		else $error("reception continued while disabled");

	pin_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(ctrl.en) |-> !serial_pin_override)
		else $error("pin still taken over after disable");

	flush_buffer_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!ctrl.en ##1 !ctrl.en |-> count == '0)
		else $error("buffer not flushed on disable");

	read_pops_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl.en && data_read && count != '0 && !push |=> count == $past(count) - 1'b1)
		else $error("data read did not pop one entry");

	start_detect_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl.en && state == ST_IDLE && sample_tick && rx_prev && !serial_input_pin |=> state == ST_START)
		else $error("falling edge not taken as start");

	noise_reject_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl.en && state == ST_START && vote_done && vote_bit |=> state == ST_IDLE)
		else $error("noisy start bit not rejected");

	stop_to_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl.en && state == ST_STOP && vote_done |=> state == ST_IDLE)
		else $error("receiver waits beyond stop vote");

	frame_error_a: assert property (@(posedge hclk) disable iff (!hresetn)
		frame_done && !vote_bit && count == '0 && !held_valid && !data_read ##1 ctrl.en
		|-> count == CNT_W'(1) && mem[rd_ptr].fe)
		else $error("low stop bit not stored as frame error");

	rxc_status_a: assert property (@(posedge hclk) disable iff (!hresetn)
		addr_valid && !hwrite && haddr[7:0] == ADDR_STATUS |=> hrdata[ST_RXC_BIT] == ($past(count) != '0))
		else $error("receive complete does not match buffer");

	overrun_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl.en && start_edge && held_valid && count == FULL_COUNT && !pop |=> held_valid && held.dor)
		else $error("overrun not flagged");

	parity_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		state == ST_STOP && !frame_pen |-> !frame_pe)
		else $error("parity error without parity check");

endmodule // asrr_rx
`default_nettype wire

// >>> tb/asrr_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
// Serial sender: one clock per sample, since the bench keeps the divider at zero
module asrr_tx_model (
	input  wire logic       hclk,
	input  wire logic       go,
	input  wire logic [7:0] data,
	input  wire logic [4:0] spb,
	input  wire logic [2:0] cnt,
	input  wire logic       use_par,
	input  wire logic       par_bit,
	input  wire logic       stop_val,
	input  wire logic [5:0] stop_smp,
	input  wire logic       glitch,
	input  wire logic       noisy,
	output logic            line,
	output logic            busy
);
	logic [9:0] fr;
	int         nb;

	// Noise hits only the middle vote sample, so a correct majority still wins
	task automatic put(input logic v, input int n, input logic flip);
		for (int s = 1; s <= n; s++) begin
			line <= v ^ (flip && s == spb / 2 + 1);
			@(posedge hclk);
		end
	endtask

	initial begin
		line = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge hclk);
			if (go) begin
				busy <= 1'b1;
				if (glitch) begin
					put(1'b0, 3, 1'b0);
				end else begin
					for (int f = 0; f < cnt; f++) begin
						fr = {par_bit, data + 8'(f * 17), 1'b0};
						nb = use_par ? 10 : 9;
						for (int b = 0; b < nb; b++) begin
							put(fr[b], spb, noisy && b > 0 && b < 9);
						end
						// Next start follows right after the stop length chosen by the bench
						put(stop_val, stop_smp, 1'b0);
					end
				end
				line <= 1'b1;
				busy <= 1'b0;
			end
		end
	end
endmodule // asrr_tx_model
`default_nettype wire

// >>> tb/asrr_rx_tb.sv
`timescale 1ns/1ps
`default_nettype none
module asrr_rx_tb;
	import asrr_pkg::*;
	localparam logic [31:0] S_RXC  = 32'h1 << ST_RXC_BIT;
	localparam logic [31:0] S_FE   = 32'h1 << ST_FE_BIT;
	localparam logic [31:0] S_DOR  = 32'h1 << ST_DOR_BIT;
	localparam logic [31:0] S_PE   = 32'h1 << ST_PE_BIT;
	localparam logic [31:0] S_BUSY = 32'h1 << ST_BUSY_BIT;
	localparam logic [31:0] S_PIN  = 32'h1 << ST_PIN_BIT;

	logic        hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, serial_pin_override, line;
	logic        m_go, m_pen, m_par, m_stop, m_glitch, m_noisy, m_busy;
	logic [7:0]  m_data;
	logic [4:0]  m_spb;
	logic [2:0]  m_cnt;
	logic [5:0]  m_ss;
	int          n_fail, total_checks;
	// Case table: control word, data, flags {glitch, noisy, stop level, parity bit}
	logic [3:0]  tc [8] = '{4'h1, 4'h1, 4'h1, 4'h7, 4'h7, 4'hf, 4'h3, 4'h3};
	logic [7:0]  td [8] = '{8'ha5, 8'hc3, 8'h00, 8'h3c, 8'h3c, 8'h3c, 8'h96, 8'h00};
	logic [3:0]  tf [8] = '{4'h2, 4'h4, 4'ha, 4'h2, 4'h3, 4'h3, 4'h6, 4'ha};

	asrr_rx asrr_rx_inst (
		.hclk                (hclk),
		.hresetn             (hresetn),
		.hsel                (hsel),
		.haddr               (haddr),
		.htrans              (htrans),
		.hwrite              (hwrite),
		.hsize               (hsize),
		.hwdata              (hwdata),
		.hready              (hreadyout),
		.hrdata              (hrdata),
		.hreadyout           (hreadyout),
		.hresp               (hresp),
		.serial_input_pin    (line),
		.serial_pin_override (serial_pin_override)
	);

	asrr_tx_model asrr_tx_model_inst (
		.hclk     (hclk),
		.go       (m_go),
		.data     (m_data),
		.spb      (m_spb),
		.cnt      (m_cnt),
		.use_par  (m_pen),
		.par_bit  (m_par),
		.stop_val (m_stop),
		.stop_smp (m_ss),
		.glitch   (m_glitch),
		.noisy    (m_noisy),
		.line     (line),
		.busy     (m_busy)
	);

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Address phase held until hready, then data phase held until hready again
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		hsel <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'(HRESP_OKAY), {31'h0, hresp});
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(a, 1'b1, d, x);
	endtask

	task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] x;
		xfer(a, 1'b0, 32'h0, x);
		chk(nm, exp, x);
	endtask

	task automatic set_ctrl(input logic [3:0] c);
		wr(32'(ADDR_CTRL), {28'h0, c});
		m_spb <= c[1] ? 5'h08 : 5'h10;
		m_pen <= c[2];
	endtask

	task automatic send(input logic [7:0] d, input logic [2:0] n, input logic [5:0] ss, input logic [3:0] fl);
		m_data <= d;
		m_cnt <= n;
		m_ss <= ss;
		{m_glitch, m_noisy, m_stop, m_par} <= fl;
		m_go <= 1'b1;
		@(posedge hclk);
		m_go <= 1'b0;
	endtask

	// Margin after the sender ends lets a rejected start finish its vote
	task automatic wait_done;
		repeat (2) @(posedge hclk);
		for (int k = 0; k < 4000 && m_busy === 1'b1; k++) @(posedge hclk);
		// A sender that never finishes is a failure, not a silent pass
		if (m_busy === 1'b1) begin
			n_fail++;
			report_and_stop;
		end
		repeat (20) @(posedge hclk);
	endtask

	initial begin
		#(4 * 40000);
		n_fail++;
		report_and_stop;
	end

	initial begin
		logic [31:0] exp;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		{m_go, m_pen, m_par, m_stop, m_glitch, m_noisy} = 6'h00;
		m_data = 8'h00;
		m_spb = 5'h10;
		m_cnt = 3'd1;
		m_ss = 6'd16;
		n_fail = 0;
		total_checks = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("pin_override", 32'h0, {31'h0, serial_pin_override});
		rd_chk("ctrl", 32'(ADDR_CTRL), 32'(CTRL_RESET));
		rd_chk("div", 32'(ADDR_DIV), 32'(DIV_RESET));
		rd_chk("status", 32'(ADDR_STATUS), 32'h0);
		rd_chk("unmapped", 32'h10, 32'h0);
		wr(32'(ADDR_DIV), 32'h1234_abcd);
		rd_chk("div", 32'(ADDR_DIV), 32'h0000_abcd);
		wr(32'(ADDR_DIV), 32'h0);
		set_ctrl(4'h1);
		rd_chk("ctrl", 32'(ADDR_CTRL), 32'h1);
		chk("pin_override", 32'h1, {31'h0, serial_pin_override});
		for (int i = 0; i < 8; i++) begin
			set_ctrl(tc[i]);
			send(td[i], 3'd1, (i == 0) ? 6'd32 : (tc[i][1] ? 6'd8 : 6'd16), tf[i]);
			wait_done;
			exp = S_PIN;
			if (!tf[i][3]) begin
				exp |= S_RXC | (tf[i][1] ? 32'h0 : S_FE);
				exp |= (tc[i][2] && (^td[i] ^ tf[i][0] ^ tc[i][3])) ? S_PE : 32'h0;
			end
			rd_chk("status", 32'(ADDR_STATUS), exp);
			rd_chk("data", 32'(ADDR_DATA), tf[i][3] ? 32'h0 : {24'h0, td[i]});
			rd_chk("status_empty", 32'(ADDR_STATUS), S_PIN);
		end
		// Four frames with shortest stop: two buffered, one held, one lost
		set_ctrl(4'h1);
		send(8'h11, 3'd4, 6'd10, 4'h2);
		wait_done;
		for (int k = 0; k < 3; k++) begin
			rd_chk("status", 32'(ADDR_STATUS), S_PIN | S_RXC | ((k == 2) ? S_DOR : 32'h0));
			rd_chk("data", 32'(ADDR_DATA), 32'(8'h11 * (k + 1)));
		end
		rd_chk("status_empty", 32'(ADDR_STATUS), S_PIN);
		// Double-speed pair: the sender holds the stop one sample past the vote window
		set_ctrl(4'h3);
		send(8'h21, 3'h2, 6'h07, 4'h2);
		wait_done;
		for (int k = 0; k < 2; k++) begin
			rd_chk("status", 32'(ADDR_STATUS), S_PIN | S_RXC);
			rd_chk("data", 32'(ADDR_DATA), 32'(8'h21 + 8'h11 * k));
		end
		rd_chk("status_empty", 32'(ADDR_STATUS), S_PIN);
		set_ctrl(4'h1);
		send(8'h5a, 3'h1, 6'h10, 4'h2);
		wait_done;
		send(8'h77, 3'd1, 6'd16, 4'h2);
		repeat (60) @(posedge hclk);
		rd_chk("status_busy", 32'(ADDR_STATUS), S_PIN | S_RXC | S_BUSY);
		set_ctrl(4'h0);
		@(posedge hclk);
		chk("pin_override", 32'h0, {31'h0, serial_pin_override});
		rd_chk("status", 32'(ADDR_STATUS), 32'h0);
		rd_chk("data", 32'(ADDR_DATA), 32'h0);
		wait_done;
		set_ctrl(4'h1);
		rd_chk("status", 32'(ADDR_STATUS), S_PIN);
		report_and_stop;
	end
endmodule // asrr_rx_tb
`default_nettype wire
